// *** verilog/crh_top.sv ***
// reset sequencing, boot hold, watchdog and interrupt forwarding of the cluster
`timescale 1ns/1ps
`include "crh_params.svh"

module crh_top #(
  parameter int SHARED_LINES = `CRH_SHARED_DEFAULT
) (
  input  wire logic                                     ref_clk,
  input  wire logic                                     rst,
  input  wire crh_pkg::crh_reset_pins_t                 reset_pins_n,
  input  wire logic [`CRH_CORE_TOP:0]                   fast_irq_req_in_n,
  input  wire logic [`CRH_CORE_TOP:0]                   normal_irq_req_in_n,
  input  wire logic [((SHARED_LINES > 0) ? SHARED_LINES : 1)-1:0] shared_irq_lines,
  input  wire crh_pkg::crh_tcm_write_t [`CRH_CORE_TOP:0] tcm_load,
  input  wire logic [`CRH_CORE_TOP:0]                   core_fetch_ack,
  input  wire logic [`CRH_CORE_TOP:0]                   wdog_kick,
  output crh_pkg::crh_domain_resets_t                   domain_reset_n_out,
  output logic [`CRH_CORE_TOP:0]                        core_fetch_valid_out,
  output logic [`CRH_CORE_TOP:0][`CRH_ADDR_W-1:0]        core_fetch_addr_out,
  output logic [`CRH_CORE_TOP:0][`CRH_TCM_DW-1:0]        core_fetch_data_out,
  output logic [`CRH_CORE_TOP:0]                        core_held_out,
  output logic [`CRH_CORE_TOP:0]                        tcm_load_refused_out,
  output logic [`CRH_CORE_TOP:0]                        watchdog_reset_request_out,
  output logic [`CRH_CORE_TOP:0]                        fast_irq_forward_out_n,
  output logic [`CRH_CORE_TOP:0]                        normal_irq_forward_out_n
);

  localparam int NC       = `CRH_NUM_CORES;
  localparam int SW       = (SHARED_LINES > 0) ? SHARED_LINES : 1;
  localparam int PIN_W    = $bits(crh_pkg::crh_reset_pins_t);
  localparam bit SHARED_OK = (SHARED_LINES % `CRH_SHARED_STEP == 0) && (SHARED_LINES <= `CRH_SHARED_MAX);
  localparam logic [`CRH_WDOG_CW-1:0] WDOG_LIMIT = `CRH_WDOG_CW'(`CRH_WDOG_CYCLES - 1);

  crh_pkg::crh_reset_pins_t rp_s;
  logic [NC-1:0]            fiq_s;
  logic [NC-1:0]            irq_s;
  logic [SW-1:0]            shr_s;

  crh_pkg::crh_core_state_t         state_r   [NC];
  crh_pkg::crh_core_state_t         state_nxt [NC];
  logic [`CRH_WDOG_CW-1:0]          wdog_cnt_r [NC];
  logic [NC-1:0]                    held_r;
  logic [NC-1:0][`CRH_TCM_AW-1:0]   tcm_rd_addr;

  // shared lines are spread over the cores by index modulo core count
  function automatic logic shared_for_core(input logic [SW-1:0] lines, input int core);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < SW; k++) begin
      if ((k % NC) == core) begin
        hit = hit | lines[k];
      end
    end
    return hit;
  endfunction

  // every pin passes two flops before use
  crh_sync #(.W(PIN_W)) u_rst_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pin_in   (reset_pins_n),
    .sync_out (rp_s)
  );

  crh_sync #(.W(2 * NC)) u_irq_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pin_in   ({fast_irq_req_in_n, normal_irq_req_in_n}),
    .sync_out ({fiq_s, irq_s})
  );

  // shared lines are active high, idle value of a sync stage is unused
  logic [SW-1:0] shr_meta_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shr_meta_r <= '0;
      shr_s      <= '0;
    end else begin
      shr_meta_r <= SHARED_OK ? shared_irq_lines : '0;
      shr_s      <= shr_meta_r;
    end
  end

  // domain resets fan out separately, held while the pin reads 0
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      domain_reset_n_out <= '0;
    end else begin
      domain_reset_n_out.core_n       <= rp_s.core_n;
      domain_reset_n_out.debug_n      <= rp_s.debug_n;
      domain_reset_n_out.wdog_n       <= rp_s.wdog_n;
      domain_reset_n_out.timer_intc_n <= rp_s.timer_intc_n;
      domain_reset_n_out.snoop_n      <= rp_s.snoop_n;
      domain_reset_n_out.cross_trig_n <= rp_s.cross_trig_n;
      domain_reset_n_out.trace0_n     <= rp_s.trace0_n;
      domain_reset_n_out.trace1_n     <= rp_s.trace1_n;
    end
  end

  // per-core boot sequence
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      state_nxt[c] = state_r[c];
      case (state_r[c])
        crh_pkg::CRH_ST_RESET: begin
          if (rp_s.core_n[c]) begin
            state_nxt[c] = rp_s.hold_n[c] ? crh_pkg::CRH_ST_RUN : crh_pkg::CRH_ST_HELD;
          end
        end
        crh_pkg::CRH_ST_HELD: begin
          if (rp_s.hold_n[c]) begin
            state_nxt[c] = crh_pkg::CRH_ST_RUN;
          end
        end
        crh_pkg::CRH_ST_RUN: begin
          state_nxt[c] = crh_pkg::CRH_ST_RUN;
        end
        default: begin
          state_nxt[c] = crh_pkg::CRH_ST_RESET;
        end
      endcase
      if (!rp_s.core_n[c]) begin
        state_nxt[c] = crh_pkg::CRH_ST_RESET;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NC; c++) begin
        state_r[c] <= crh_pkg::CRH_ST_RESET;
      end
    end else begin
      for (int c = 0; c < NC; c++) begin
        state_r[c] <= state_nxt[c];
      end
    end
  end

  // held indication and preload permission
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      held_r        <= '0;
      core_held_out <= '0;
    end else begin
      for (int c = 0; c < NC; c++) begin
        held_r[c]        <= (state_nxt[c] == crh_pkg::CRH_ST_HELD);
        core_held_out[c] <= (state_nxt[c] == crh_pkg::CRH_ST_HELD);
      end
    end
  end

  // fetch stream, no fetch outside run
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      core_fetch_valid_out <= '0;
      core_fetch_addr_out  <= '0;
    end else begin
      for (int c = 0; c < NC; c++) begin
        if (state_nxt[c] != crh_pkg::CRH_ST_RUN) begin
          core_fetch_valid_out[c] <= 1'b0;
          core_fetch_addr_out[c]  <= `CRH_RESET_VECTOR;
        end else begin
          core_fetch_valid_out[c] <= 1'b1;
          if (core_fetch_valid_out[c] && core_fetch_ack[c]) begin
            core_fetch_addr_out[c] <= core_fetch_addr_out[c] + `CRH_FETCH_STEP;
          end
        end
      end
    end
  end

  // memory per core, read follows the next fetch address
  for (genvar g = 0; g < NC; g++) begin : g_tcm
    always_comb begin
      if (core_fetch_valid_out[g] && core_fetch_ack[g]) begin
        tcm_rd_addr[g] = core_fetch_addr_out[g][`CRH_TCM_AW+1:2] + `CRH_TCM_AW'(1);
      end else if (state_nxt[g] != crh_pkg::CRH_ST_RUN) begin
        tcm_rd_addr[g] = `CRH_TCM_AW'(`CRH_RESET_VECTOR >> 2);
      end else begin
        tcm_rd_addr[g] = core_fetch_addr_out[g][`CRH_TCM_AW+1:2];
      end
    end

    crh_tcm u_tcm (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .load_allow   (held_r[g]),
      .load_wr      (tcm_load[g]),
      .rd_addr      (tcm_rd_addr[g]),
      .rd_data      (core_fetch_data_out[g]),
      .load_refused (tcm_load_refused_out[g])
    );
  end

  // watchdog per core, request stands until its reset domain is asserted
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NC; c++) begin
        wdog_cnt_r[c] <= '0;
      end
      watchdog_reset_request_out <= '0;
    end else begin
      for (int c = 0; c < NC; c++) begin
        if (!rp_s.wdog_n[c]) begin
          wdog_cnt_r[c]                 <= '0;
          watchdog_reset_request_out[c] <= 1'b0;
        end else if (state_r[c] != crh_pkg::CRH_ST_RUN || wdog_kick[c]) begin
          wdog_cnt_r[c] <= '0;
        end else if (wdog_cnt_r[c] == WDOG_LIMIT) begin
          watchdog_reset_request_out[c] <= 1'b1;
        end else begin
          wdog_cnt_r[c] <= wdog_cnt_r[c] + `CRH_WDOG_CW'(1);
        end
      end
    end
  end

  // fast forwards follow the request level each cycle, normal forwards follow the request or, while timer_intc_n reads 1, the core's shared lines
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fast_irq_forward_out_n   <= '1;
      normal_irq_forward_out_n <= '1;
    end else begin
      for (int c = 0; c < NC; c++) begin
        fast_irq_forward_out_n[c] <= fiq_s[c];
        normal_irq_forward_out_n[c] <=
          !((!irq_s[c]) ||
            (SHARED_LINES > 0 && rp_s.timer_intc_n && shared_for_core(shr_s, c)));
      end
    end
  end

endmodule

// *** verilog/crh_params.svh ***
// constants for the core reset, boot hold and interrupt pin block
`ifndef CRH_PARAMS_SVH
`define CRH_PARAMS_SVH

// processor count and per-processor vector top index
`define CRH_NUM_CORES        2
`define CRH_CORE_TOP         (`CRH_NUM_CORES - 1)

// shared distributor lines: 0 or 32..480 in steps of 32
`define CRH_SHARED_STEP      32
`define CRH_SHARED_MAX       480
`define CRH_SHARED_DEFAULT   32

// tightly coupled memory preload window per core
`define CRH_TCM_DEPTH        16
`define CRH_TCM_AW           4
`define CRH_TCM_DW           32
`define CRH_TCM_RESET_WORD   32'h0000_0000

// fetch address after reset or hold release
`define CRH_ADDR_W           32
`define CRH_RESET_VECTOR     32'h0000_0000
`define CRH_FETCH_STEP       32'h0000_0004

// watchdog timeout, time in microseconds and clock rate
`define CRH_CLK_MHZ          25
`define CRH_WDOG_TIMEOUT_US  100
`define CRH_WDOG_CYCLES      (`CRH_WDOG_TIMEOUT_US * `CRH_CLK_MHZ)
`define CRH_WDOG_CW          12

// synchroniser depth and reset value of an idle active-low pin
`define CRH_SYNC_STAGES      2
`define CRH_PIN_IDLE         1'b1

`endif

// *** verilog/crh_pkg.sv ***
// types for the core reset, boot hold and interrupt pin block
`include "crh_params.svh"

package crh_pkg;

  typedef enum logic [1:0] {
    CRH_ST_RESET = 2'b00,
    CRH_ST_HELD  = 2'b01,
    CRH_ST_RUN   = 2'b10
  } crh_core_state_t;

  typedef struct packed {
    logic [`CRH_CORE_TOP:0] core_n;
    logic [`CRH_CORE_TOP:0] hold_n;
    logic [`CRH_CORE_TOP:0] debug_n;
    logic [`CRH_CORE_TOP:0] wdog_n;
    logic                   timer_intc_n;
    logic                   snoop_n;
    logic                   cross_trig_n;
    logic                   trace0_n;
    logic                   trace1_n;
  } crh_reset_pins_t;

  typedef struct packed {
    logic [`CRH_CORE_TOP:0] core_n;
    logic [`CRH_CORE_TOP:0] debug_n;
    logic [`CRH_CORE_TOP:0] wdog_n;
    logic                   timer_intc_n;
    logic                   snoop_n;
    logic                   cross_trig_n;
    logic                   trace0_n;
    logic                   trace1_n;
  } crh_domain_resets_t;

  typedef struct packed {
    logic                   valid;
    logic [`CRH_TCM_AW-1:0] addr;
    logic [`CRH_TCM_DW-1:0] data;
  } crh_tcm_write_t;

endpackage

// *** verilog/crh_sync.sv ***
// two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`include "crh_params.svh"

module crh_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // idle level of every active-low pin is high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r   <= {W{`CRH_PIN_IDLE}};
      sync_out <= {W{`CRH_PIN_IDLE}};
    end else begin
      meta_r   <= pin_in;
      sync_out <= meta_r;
    end
  end

endmodule

// *** verilog/crh_tcm.sv ***
// tightly coupled memory of one core with preload write and fetch read
`timescale 1ns/1ps
`include "crh_params.svh"

module crh_tcm (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    load_allow,
  input  wire crh_pkg::crh_tcm_write_t load_wr,
  input  wire logic [`CRH_TCM_AW-1:0]  rd_addr,
  output logic      [`CRH_TCM_DW-1:0]  rd_data,
  output logic                         load_refused
);

  logic [`CRH_TCM_DW-1:0] mem_r [`CRH_TCM_DEPTH];

  // preload only accepted while the core is held
  always_ff @(posedge ref_clk) begin
    if (load_wr.valid && load_allow) begin
      mem_r[load_wr.addr] <= load_wr.data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data <= `CRH_TCM_RESET_WORD;
    end else begin
      rd_data <= mem_r[rd_addr];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      load_refused <= 1'b0;
    end else begin
      load_refused <= load_wr.valid && !load_allow;
    end
  end

endmodule

// *** verification/crh_top_props.sv ***
// checker for the core reset, boot hold and interrupt pin block
`timescale 1ns/1ps
`include "crh_params.svh"
module crh_top_props #(
  parameter int SHARED_LINES = `CRH_SHARED_DEFAULT
) (
  input wire logic                                      ref_clk,
  input wire logic                                      rst,
  input wire crh_pkg::crh_reset_pins_t                  reset_pins_n,
  input wire logic [`CRH_CORE_TOP:0]                    fast_irq_req_in_n,
  input wire logic [`CRH_CORE_TOP:0]                    normal_irq_req_in_n,
  input wire crh_pkg::crh_tcm_write_t [`CRH_CORE_TOP:0] tcm_load,
  input wire logic [`CRH_CORE_TOP:0]                    core_fetch_ack,
  input wire logic [`CRH_CORE_TOP:0]                    wdog_kick,
  input wire crh_pkg::crh_domain_resets_t               domain_reset_n_out,
  input wire logic [`CRH_CORE_TOP:0]                    core_fetch_valid_out,
  input wire logic [`CRH_CORE_TOP:0][`CRH_ADDR_W-1:0]   core_fetch_addr_out,
  input wire logic [`CRH_CORE_TOP:0]                    core_held_out,
  input wire logic [`CRH_CORE_TOP:0]                    tcm_load_refused_out,
  input wire logic [`CRH_CORE_TOP:0]                    watchdog_reset_request_out,
  input wire logic [`CRH_CORE_TOP:0]                    fast_irq_forward_out_n,
  input wire logic [`CRH_CORE_TOP:0]                    normal_irq_forward_out_n
);
  logic [1:0]                  up_cnt;
  logic [11:0]                 run_cnt;
  crh_pkg::crh_domain_resets_t dom_pins;
  assign dom_pins = {reset_pins_n.core_n, reset_pins_n.debug_n, reset_pins_n.wdog_n, reset_pins_n[4:0]};
  // cycles since reset release, saturating
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) up_cnt <= 2'h0;
    else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
  end
  // unkicked running cycles of core 1
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) run_cnt <= 12'h0;
    else if (!core_fetch_valid_out[1] || wdog_kick[1]) run_cnt <= 12'h0;
    else if (run_cnt != 12'hfff) run_cnt <= run_cnt + 12'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_fast_fwd_level: assert property (up_cnt == 2'h3 |->
    fast_irq_forward_out_n == $past(fast_irq_req_in_n, 3)) else $error("fast forward not following request");
  a_normal_fwd_set: assert property (up_cnt == 2'h3 |->
    (~$past(normal_irq_req_in_n, 3) & normal_irq_forward_out_n) == '0) else $error("normal request not forwarded");
  a_hold_no_fetch: assert property ((core_held_out & core_fetch_valid_out) == '0)
    else $error("held core fetching");
  a_fetch_from_vector: assert property ($rose(core_fetch_valid_out[0]) |->
    core_fetch_addr_out[0] == `CRH_RESET_VECTOR) else $error("fetch not at reset vector");
  a_fetch_addr_step: assert property (core_fetch_valid_out[0] && core_fetch_ack[0] |=> !core_fetch_valid_out[0] ||
    core_fetch_addr_out[0] == $past(core_fetch_addr_out[0]) + `CRH_FETCH_STEP) else $error("fetch step wrong");
  a_domain_reset_follow: assert property (up_cnt == 2'h3 |->
    domain_reset_n_out == $past(dom_pins, 3)) else $error("domain reset not following pin");
  a_wdog_pin_clear: assert property (up_cnt == 2'h3 |->
    (~$past(reset_pins_n.wdog_n, 3) & watchdog_reset_request_out) == '0) else $error("request kept in reset");
  a_wdog_not_early: assert property ($rose(watchdog_reset_request_out[1]) |-> run_cnt >= 12'h9ba)
    else $error("watchdog request too early");
  a_refused_pulse: assert property (up_cnt != 2'h0 |-> tcm_load_refused_out ==
    $past({tcm_load[1].valid, tcm_load[0].valid} & ~core_held_out)) else $error("refused pulse wrong");
  c_held: cover property (core_held_out[0]);
  c_wdog: cover property ($rose(watchdog_reset_request_out[1]));
  c_refused: cover property (tcm_load_refused_out[1]);
endmodule
bind crh_top crh_top_props #(.SHARED_LINES(SHARED_LINES)) u_props (.*);

// *** verification/crh_partner.sv ***
// model of reset controller, interrupt sources and power controller
`timescale 1ns/1ps
module crh_partner (
  input  wire logic              ref_clk,
  input  wire logic [1:0]        fast_fwd_n,
  input  wire logic [1:0]        normal_fwd_n,
  output crh_pkg::crh_reset_pins_t pins_n,
  output logic [1:0]             fast_n,
  output logic [1:0]             normal_n,
  output logic [31:0]            shared
);
  initial begin
    pins_n = '1;
    pins_n.core_n = 2'h0;
    pins_n.hold_n = 2'h2;
    fast_n = 2'h3;
    normal_n = 2'h3;
    shared = 32'h0;
  end
  task automatic drive_pins(input crh_pkg::crh_reset_pins_t v);
    @(negedge ref_clk);
    pins_n = v;
  endtask
  task automatic drive_shared(input logic [31:0] v);
    @(negedge ref_clk);
    shared = v;
  endtask
  // request held low until seen forwarded, for at most 8 cycles
  task automatic irq_until_fwd(input bit fast, input int core, output bit seen);
    seen = 1'b0;
    @(negedge ref_clk);
    if (fast) fast_n[core] = 1'b0;
    else normal_n[core] = 1'b0;
    for (int i = 0; i < 8 && !seen; i++) begin
      @(negedge ref_clk);
      seen = fast ? !fast_fwd_n[core] : !normal_fwd_n[core];
    end
    if (fast) fast_n[core] = 1'b1;
    else normal_n[core] = 1'b1;
  endtask
endmodule

// *** verification/crh_top_tb.sv ***
// self-checking bench for the core reset, boot hold and interrupt pin block
`timescale 1ns/1ps
module crh_top_tb;
  logic                          ref_clk;
  logic                          rst;
  crh_pkg::crh_reset_pins_t      pins_n;
  crh_pkg::crh_reset_pins_t      p;
  logic [1:0]                    fast_n, normal_n, fast_fwd_n, normal_fwd_n;
  logic [1:0]                    ack, kick, valid, held, refused, wd_req;
  logic [31:0]                   shared;
  crh_pkg::crh_tcm_write_t [1:0] load;
  crh_pkg::crh_domain_resets_t   dom;
  logic [1:0][31:0]              addr, data;
  int                            n_fail, compares, hits, i;
  bit                            seen;
  crh_top #(.SHARED_LINES(32)) uut (.ref_clk(ref_clk), .rst(rst), .reset_pins_n(pins_n), .fast_irq_req_in_n(fast_n),
    .normal_irq_req_in_n(normal_n), .shared_irq_lines(shared), .tcm_load(load), .core_fetch_ack(ack), .wdog_kick(kick),
    .domain_reset_n_out(dom), .core_fetch_valid_out(valid), .core_fetch_addr_out(addr), .core_fetch_data_out(data),
    .core_held_out(held), .tcm_load_refused_out(refused), .watchdog_reset_request_out(wd_req),
    .fast_irq_forward_out_n(fast_fwd_n), .normal_irq_forward_out_n(normal_fwd_n));
  crh_partner partner (.ref_clk(ref_clk), .fast_fwd_n(fast_fwd_n),
    .normal_fwd_n(normal_fwd_n), .pins_n(pins_n), .fast_n(fast_n), .normal_n(normal_n), .shared(shared));
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic complete_run;
    $display("counts: compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_reset_state;
    chk("core resets", 2'h0, dom.core_n);
    chk("shared unit resets", 5'h1f, dom[4:0]);
    chk("forwards idle", 4'hf, {fast_fwd_n, normal_fwd_n});
    $display("test reset_state done");
  endtask
  task automatic t_boot_hold;
    p = pins_n;
    p.core_n = 2'h3;
    partner.drive_pins(p);
    step(4);
    chk("held", held, 2'h1);
    chk("valid", valid, 2'h2);
    load[0] = {1'b1, 4'h0, 32'h1111_aaaa};
    step(1);
    load[0] = {1'b1, 4'h1, 32'h2222_bbbb};
    step(1);
    load[0] = '0;
    step(8);
    chk("still held", {held[0], valid[0]}, 2'h2);
    p.hold_n = 2'h3;
    partner.drive_pins(p);
    step(4);
    chk("fetch valid", valid[0], 1'b1);
    chk("fetch addr", addr[0], 32'h0);
    chk("fetch data", data[0], 32'h1111_aaaa);
    ack = 2'h1;
    step(1);
    ack = 2'h0;
    chk("next addr", addr[0], 32'h4);
    chk("next data", data[0], 32'h2222_bbbb);
    $display("test boot_hold done");
  endtask
  task automatic t_refuse;
    load[1] = {1'b1, 4'h2, 32'h3};
    step(1);
    load[1] = '0;
    hits = 0;
    repeat (3) begin
      if (refused[1] === 1'b1) hits++;
      step(1);
    end
    chk("refused pulses", hits, 1);
    $display("test refuse done");
  endtask
  task automatic t_irq;
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 2; c++) begin
        partner.irq_until_fwd(f[0], c, seen);
        chk("forward seen", seen, 1'b1);
        step(4);
        chk("forward released", {fast_fwd_n, normal_fwd_n}, 4'hf);
      end
    end
    partner.drive_shared(32'h2);
    step(4);
    chk("shared to core 1", normal_fwd_n, 2'h1);
    p.timer_intc_n = 1'b0;
    partner.drive_pins(p);
    step(4);
    chk("shared gated", normal_fwd_n, 2'h3);
    p.timer_intc_n = 1'b1;
    partner.drive_pins(p);
    partner.drive_shared(32'h0);
    step(4);
    $display("test irq done");
  endtask
  task automatic t_watchdog;
    kick = 2'h2;
    step(1);
    kick = 2'h0;
    for (i = 0; i < 3000 && wd_req[1] !== 1'b1; i++) step(1);
    chk("timeout request", wd_req[1], 1'b1);
    chk("timeout span", (i >= 2495 && i <= 2505), 1'b1);
    kick = 2'h2;
    step(3);
    chk("kick ignored", wd_req[1], 1'b1);
    p.wdog_n = 2'h1;
    partner.drive_pins(p);
    step(4);
    chk("request cleared", wd_req[1], 1'b0);
    p.wdog_n = 2'h3;
    partner.drive_pins(p);
    step(1);
    kick = 2'h0;
    $display("test watchdog done");
  endtask
  initial begin
    rst = 1'b1;
    ack = 2'h0;
    kick = 2'h0;
    load = '0;
    n_fail = 0;
    compares = 0;
    step(2);
    rst = 1'b0;
    step(4);
    t_reset_state();
    t_boot_hold();
    t_refuse();
    t_irq();
    t_watchdog();
    complete_run();
  end
  initial begin
    #200000;
    n_fail++;
    $display("watchdog expired");
    complete_run();
  end
endmodule
